// [hw/pcm_pkg.sv]
// Package for the third-port signal mux: modes, bit positions, carriers.
// Assumes a single 20 MHz clock domain and synchronous pin inputs.
package pcm_pkg;

  localparam int unsigned PORT_W      = 8;
  localparam int unsigned NIB_W       = 4;

  // Group A mode codes (2 bits), group B mode codes (2 bits)
  typedef enum logic [1:0] {
    PCM_A_SIMPLE,
    PCM_A_STB_IN,
    PCM_A_STB_OUT,
    PCM_A_BIDIR
  } pcm_amode_t;

  typedef enum logic [1:0] {
    PCM_B_SIMPLE,
    PCM_B_STB_IN,
    PCM_B_STB_OUT
  } pcm_bmode_t;

  // Bit positions on the third port
  localparam int unsigned BIT_A_OFULL = 7;
  localparam int unsigned BIT_A_ACK   = 6;
  localparam int unsigned BIT_A_IFULL = 5;
  localparam int unsigned BIT_A_STB   = 4;
  localparam int unsigned BIT_A_IRQ   = 3;
  localparam int unsigned BIT_B_HSIN  = 2;
  localparam int unsigned BIT_B_FULL  = 1;
  localparam int unsigned BIT_B_IRQ   = 0;

  // Reset values
  localparam logic RST_IFULL   = 1'b0;
  localparam logic RST_OFULL_N = 1'b1;

  // Configuration carrier from the host side
  typedef struct packed {
    pcm_amode_t        a_mode;
    pcm_bmode_t        b_mode;
    logic              a_ien_in;
    logic              a_ien_out;
    logic              b_ien;
    logic              gp_hi_dir;
    logic              gp_lo_dir;
  } pcm_cfg_t;

  // Host-side data events per group
  typedef struct packed {
    logic host_wr;
    logic host_rd;
  } pcm_evt_t;

  // Handshake status per group, seen by the host
  typedef struct packed {
    logic in_full;
    logic out_full;
    logic irq;
  } pcm_stat_t;

endpackage : pcm_pkg

// [hw/pcm_third_port_mux.sv]
// Third-port signal mux: handshake lines and general-purpose bits.
// Assumes host-side config and data events come from the register logic.
`timescale 1ns/1ps

module pcm_third_port_mux #(
  parameter int unsigned PORT_W = pcm_pkg::PORT_W
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire pcm_pkg::pcm_cfg_t          cfg,
  input  wire logic                       cfg_valid,
  input  wire pcm_pkg::pcm_evt_t          evt_a,
  input  wire pcm_pkg::pcm_evt_t          evt_b,
  input  wire logic [PORT_W-1:0]          gp_out,
  input  wire logic [PORT_W-1:0]          port_in,
  output logic      [PORT_W-1:0]          port_out,
  output logic      [PORT_W-1:0]          port_oe,
  output logic      [PORT_W-1:0]          gp_in,
  output logic                            a_latch,
  output logic                            b_latch,
  output pcm_pkg::pcm_stat_t              stat_a,
  output pcm_pkg::pcm_stat_t              stat_b
);

  // Bit positions are fixed, so only the documented width can work
  if (PORT_W != pcm_pkg::PORT_W)
  begin : g_bad_width
    $error("Third port must be 8 bits wide");
  end

  // Shared bit layout for every instance, so no per-instance remap
  localparam int unsigned NIB = pcm_pkg::NIB_W;

  pcm_pkg::pcm_cfg_t cfg_r, cfg_nxt;
  logic a_ifull_r, a_ifull_nxt, a_ofn_r, a_ofn_nxt;
  logic b_full_r,  b_full_nxt;
  logic a_stb_d_r, b_hs_d_r, a_ack_d_r;
  logic a_in, a_out, b_in, b_out, b_hs;
  logic a_stb_fall, a_ack_fall, b_hs_fall;
  logic a_irq, b_irq;
  logic [PORT_W-1:0] claim, hs_val, hs_oe, gp_dir;

  always_comb
  begin
    cfg_nxt = cfg_valid ? cfg : cfg_r;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cfg_r <= '0;
    else
      cfg_r <= cfg_nxt;
  end

  // Group A decodes alone; group B decode also depends on the group A mode
  assign a_in  = (cfg_r.a_mode == pcm_pkg::PCM_A_STB_IN) ||
                 (cfg_r.a_mode == pcm_pkg::PCM_A_BIDIR);
  assign a_out = (cfg_r.a_mode == pcm_pkg::PCM_A_STB_OUT) ||
                 (cfg_r.a_mode == pcm_pkg::PCM_A_BIDIR);
  // Bidirectional A turns the B handshake off, though A claims only bits 7..3
  assign b_in  = (cfg_r.b_mode == pcm_pkg::PCM_B_STB_IN) &&
                 (cfg_r.a_mode != pcm_pkg::PCM_A_BIDIR);
  assign b_out = (cfg_r.b_mode == pcm_pkg::PCM_B_STB_OUT) &&
                 (cfg_r.a_mode != pcm_pkg::PCM_A_BIDIR);
  assign b_hs  = port_in[pcm_pkg::BIT_B_HSIN];

  // Falling edges of active-low inputs
  assign a_stb_fall = a_stb_d_r & ~port_in[pcm_pkg::BIT_A_STB];
  assign a_ack_fall = a_ack_d_r & ~port_in[pcm_pkg::BIT_A_ACK];
  assign b_hs_fall  = b_hs_d_r & ~b_hs;
  assign a_latch    = a_in & a_stb_fall;
  assign b_latch    = b_in & b_hs_fall;

  always_comb
  begin
    a_ifull_nxt = a_ifull_r;
    if (!a_in)
      a_ifull_nxt = 1'b0;
    else if (a_latch)
      a_ifull_nxt = 1'b1;
    else if (evt_a.host_rd)
      a_ifull_nxt = 1'b0;
    a_ofn_nxt = a_ofn_r;
    if (!a_out)
      a_ofn_nxt = 1'b1;
    else if (evt_a.host_wr)
      a_ofn_nxt = 1'b0;
    else if (a_ack_fall)
      a_ofn_nxt = 1'b1;
    b_full_nxt = b_full_r;
    if (b_in)
    begin
      if (b_latch)
        b_full_nxt = 1'b1;
      else if (evt_b.host_rd)
        b_full_nxt = 1'b0;
    end
    else if (b_out)
    begin
      if (evt_b.host_wr)
        b_full_nxt = 1'b1;
      else if (b_hs_fall)
        b_full_nxt = 1'b0;
    end
    else
      b_full_nxt = 1'b0;
    // Mode write restarts every handshake, so no stale flag leaks
    if (cfg_valid)
    begin
      a_ifull_nxt = pcm_pkg::RST_IFULL;
      a_ofn_nxt   = pcm_pkg::RST_OFULL_N;
      b_full_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      a_ifull_r <= pcm_pkg::RST_IFULL;
      a_ofn_r   <= pcm_pkg::RST_OFULL_N;
      b_full_r  <= 1'b0;
      a_stb_d_r <= 1'b1;
      a_ack_d_r <= 1'b1;
      b_hs_d_r  <= 1'b1;
    end
    else
    begin
      a_ifull_r <= a_ifull_nxt;
      a_ofn_r   <= a_ofn_nxt;
      b_full_r  <= b_full_nxt;
      a_stb_d_r <= port_in[pcm_pkg::BIT_A_STB];
      a_ack_d_r <= port_in[pcm_pkg::BIT_A_ACK];
      b_hs_d_r  <= b_hs;
    end
  end

  // Service request: input full, or output buffer emptied
  assign a_irq = (a_in & cfg_r.a_ien_in & a_ifull_r) |
                 (a_out & cfg_r.a_ien_out & a_ofn_r);
  assign b_irq = cfg_r.b_ien & ((b_in & b_full_r) | (b_out & ~b_full_r));

  // Claimed bits, values and enables per mode
  always_comb
  begin
    claim  = '0;
    hs_val = '0;
    hs_oe  = '0;
    unique case (cfg_r.a_mode)
      pcm_pkg::PCM_A_SIMPLE:
        claim = claim;
      pcm_pkg::PCM_A_STB_IN:
      begin
        claim[5:3] = 3'h7;
        hs_oe[pcm_pkg::BIT_A_IFULL] = 1'b1;
        hs_val[pcm_pkg::BIT_A_IFULL] = a_ifull_r;
      end
      pcm_pkg::PCM_A_STB_OUT:
      begin
        claim[7:6] = 2'h3;
        claim[pcm_pkg::BIT_A_IRQ] = 1'b1;
        hs_oe[pcm_pkg::BIT_A_OFULL] = 1'b1;
        hs_val[pcm_pkg::BIT_A_OFULL] = a_ofn_r;
      end
      pcm_pkg::PCM_A_BIDIR:
      begin
        claim[7:3] = 5'h1f;
        hs_oe[pcm_pkg::BIT_A_OFULL] = 1'b1;
        hs_val[pcm_pkg::BIT_A_OFULL] = a_ofn_r;
        hs_oe[pcm_pkg::BIT_A_IFULL] = 1'b1;
        hs_val[pcm_pkg::BIT_A_IFULL] = a_ifull_r;
      end
    endcase
    if (cfg_r.a_mode != pcm_pkg::PCM_A_SIMPLE)
    begin
      hs_oe[pcm_pkg::BIT_A_IRQ]  = 1'b1;
      hs_val[pcm_pkg::BIT_A_IRQ] = a_irq;
    end
    // Bidirectional A leaves bits 2..0 general-purpose
    if ((b_in | b_out) && cfg_r.a_mode != pcm_pkg::PCM_A_BIDIR)
    begin
      claim[2:0] = 3'h7;
      hs_oe[pcm_pkg::BIT_B_FULL]  = 1'b1;
      hs_val[pcm_pkg::BIT_B_FULL] = b_in ? b_full_r : ~b_full_r;
      hs_oe[pcm_pkg::BIT_B_IRQ]   = 1'b1;
      hs_val[pcm_pkg::BIT_B_IRQ]  = b_irq;
    end
  end

  assign gp_dir = {{NIB{cfg_r.gp_hi_dir}}, {NIB{cfg_r.gp_lo_dir}}};

  // Unclaimed lines follow the nibble direction; reset leaves all off
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++)
    begin : g_bit
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          port_oe[gi]  <= 1'b0;
          port_out[gi] <= 1'b0;
          gp_in[gi]    <= 1'b0;
        end
        else
        begin
          port_oe[gi]  <= claim[gi] ? hs_oe[gi] : gp_dir[gi];
          port_out[gi] <= claim[gi] ? hs_val[gi] : gp_out[gi];
          gp_in[gi]    <= claim[gi] ? 1'b0 : port_in[gi];
        end
      end
    end
  endgenerate

  assign stat_a = '{in_full: a_ifull_r, out_full: ~a_ofn_r, irq: a_irq};
  assign stat_b = '{in_full: b_in & b_full_r, out_full: b_out & b_full_r, irq: b_irq};

  a_reset_quiet: assert property (@(posedge clk) $rose(nrst) |-> port_oe == '0)
    else $error("Lines driven right after reset");
  a_latch_sets_full: assert property (@(posedge clk) disable iff (!nrst)
    (a_latch && !cfg_valid) |=> a_ifull_r)
    else $error("Input full not set after strobe");
  a_write_lowers_full: assert property (@(posedge clk) disable iff (!nrst)
    (a_out && evt_a.host_wr && !cfg_valid) |=> ##1 (port_out[7] == 1'b0 && port_oe[7]))
    else $error("Output full line not low after write");
  a_ack_clears_full: assert property (@(posedge clk) disable iff (!nrst)
    (a_out && !evt_a.host_wr && a_ack_fall) |=> a_ofn_r)
    else $error("Ack did not clear output full");
  a_irq_needs_en: assert property (@(posedge clk) disable iff (!nrst)
    (!cfg_r.b_ien && (b_in || b_out)) |=> !port_out[pcm_pkg::BIT_B_IRQ])
    else $error("Group B irq without enable");
  a_stbin_map: assert property (@(posedge clk) disable iff (!nrst)
    (cfg_r.a_mode == pcm_pkg::PCM_A_STB_IN && $stable(cfg_r)) |=>
    (port_oe[5] && port_out[5] == $past(a_ifull_r) && !port_oe[4]))
    else $error("Strobed input map wrong");
  a_stbout_map: assert property (@(posedge clk) disable iff (!nrst)
    (cfg_r.a_mode == pcm_pkg::PCM_A_STB_OUT && $stable(cfg_r)) |=>
    (!port_oe[6] && port_oe[7] && port_oe[3]))
    else $error("Strobed output map wrong");
  a_bidir_map: assert property (@(posedge clk) disable iff (!nrst)
    (cfg_r.a_mode == pcm_pkg::PCM_A_BIDIR && $stable(cfg_r)) |=>
    (port_oe[2:0] == {3{$past(cfg_r.gp_lo_dir)}} && !port_oe[4]))
    else $error("Bidirectional map wrong");
  a_simple_dir: assert property (@(posedge clk) disable iff (!nrst)
    (cfg_r.a_mode == pcm_pkg::PCM_A_SIMPLE && !b_in && !b_out && $stable(cfg_r)) |=>
    port_oe == {{4{$past(cfg_r.gp_hi_dir)}}, {4{$past(cfg_r.gp_lo_dir)}}})
    else $error("Simple mode direction wrong");

  c_in_xfer:  cover property (@(posedge clk) disable iff (!nrst) a_latch ##[1:20] evt_a.host_rd);
  c_out_xfer: cover property (@(posedge clk) disable iff (!nrst)
    (a_out && evt_a.host_wr) ##[1:20] a_ack_fall);
  c_mixed:    cover property (@(posedge clk) disable iff (!nrst)
    cfg_r.a_mode == pcm_pkg::PCM_A_STB_IN && b_out);
  c_b_irq:    cover property (@(posedge clk) disable iff (!nrst) b_irq);

endmodule : pcm_third_port_mux

// [test/pcm_ext_dev.sv]
// External handshake device on the third port.
// Assumes the bench names, by bit, which handshake line to pulse low.
`timescale 1ns/1ps

module pcm_ext_dev (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe,
  input  wire logic [7:0] pulse_req,
  input  wire logic [7:0] gp_drv,
  output logic      [7:0] port_in
);
  logic [7:0] low1_r;
  logic [7:0] low2_r;

  // Two low cycles so the fall is seen between two samples
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low1_r <= '0;
      low2_r <= '0;
    end
    else
    begin
      low1_r <= pulse_req;
      low2_r <= low1_r;
    end
  end

  // Released lines rest at the pulled-up or bench level, never stale
  assign port_in = (port_oe & port_out) | (~port_oe & gp_drv & ~(low1_r | low2_r));
endmodule : pcm_ext_dev

// [test/tb_ppi_port_c_signal_mux.sv]
// Bench for the third-port mux, far side played by pcm_ext_dev.
// Assumes one 20 MHz clock; outputs are judged at the falling edge.
`timescale 1ns/1ps

module tb_ppi_port_c_signal_mux;
  logic               clk;
  logic               nrst;
  pcm_pkg::pcm_cfg_t  cfg;
  logic               cfg_valid;
  pcm_pkg::pcm_evt_t  evt_a;
  pcm_pkg::pcm_evt_t  evt_b;
  logic [7:0]         gp_out;
  logic [7:0]         gp_drv;
  logic [7:0]         pulse_req;
  logic [7:0]         port_in;
  logic [7:0]         port_out;
  logic [7:0]         port_oe;
  logic [7:0]         gp_in;
  logic               a_latch;
  logic               b_latch;
  pcm_pkg::pcm_stat_t stat_a;
  pcm_pkg::pcm_stat_t stat_b;
  int                 n_errors;
  int                 comparisons;
  int                 n_la;
  int                 n_lb;

  pcm_third_port_mux DUT (.clk(clk), .nrst(nrst), .cfg(cfg), .cfg_valid(cfg_valid),
    .evt_a(evt_a), .evt_b(evt_b), .gp_out(gp_out), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .gp_in(gp_in), .a_latch(a_latch), .b_latch(b_latch),
    .stat_a(stat_a), .stat_b(stat_b));
  pcm_ext_dev ext (.clk(clk), .nrst(nrst), .port_out(port_out), .port_oe(port_oe),
    .pulse_req(pulse_req), .gp_drv(gp_drv), .port_in(port_in));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick

  task automatic set_cfg(input pcm_pkg::pcm_cfg_t c);
    @(posedge clk);
    cfg <= c;
    cfg_valid <= 1'b1;
    @(posedge clk);
    cfg_valid <= 1'b0;
    tick(3);
  endtask : set_cfg

  // Group 0 is A; wr 0 means the host read the input latch
  task automatic evt(input logic grp, input logic wr);
    @(posedge clk);
    if (grp)
      evt_b <= '{host_wr: wr, host_rd: !wr};
    else
      evt_a <= '{host_wr: wr, host_rd: !wr};
    @(posedge clk);
    evt_a <= '0;
    evt_b <= '0;
    tick(3);
  endtask : evt

  task automatic strobe(input int i);
    @(posedge clk);
    pulse_req[i] <= 1'b1;
    @(posedge clk);
    pulse_req <= '0;
    tick(4);
  endtask : strobe

  task automatic t_simple;
    set_cfg('{pcm_pkg::PCM_A_SIMPLE, pcm_pkg::PCM_B_SIMPLE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    check("simple oe", port_oe, 8'hf0);
    check("simple out", port_out & 8'hf0, 8'ha0);
    check("simple gp_in", gp_in, 8'hac);
  endtask : t_simple

  task automatic t_stb_in;
    set_cfg('{pcm_pkg::PCM_A_STB_IN, pcm_pkg::PCM_B_STB_IN, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0});
    check("stb_in oe", port_oe, 8'heb);
    check("stb_in idle", port_out & 8'h2b, 8'h00);
    check("stb_in gp_in", gp_in, 8'h80);
    strobe(4);
    check("a latch pulses", 8'(n_la), 8'h01);
    check("a full irq", port_out & 8'h2b, 8'h28);
    check("a in_full", {7'h00, stat_a.in_full}, 8'h01);
    strobe(2);
    check("b full irq", port_out & 8'h2b, 8'h2b);
    check("b stat in", {5'h00, stat_b}, 8'h05);
    check("b latch pulses", 8'(n_lb), 8'h01);
    evt(1'b0, 1'b0);
    check("a read clears", port_out & 8'h2b, 8'h03);
  endtask : t_stb_in

  task automatic t_stb_out;
    set_cfg('{pcm_pkg::PCM_A_STB_OUT, pcm_pkg::PCM_B_STB_OUT, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0});
    check("stb_out oe", port_oe, 8'hbb);
    check("stb_out idle", port_out & 8'hba, 8'haa);
    evt(1'b0, 1'b1);
    check("a written", port_out & 8'hba, 8'h22);
    check("a stat written", {5'h00, stat_a}, 8'h02);
    evt(1'b1, 1'b1);
    check("b written", port_out & 8'hba, 8'h20);
    check("b stat written", {5'h00, stat_b}, 8'h02);
    strobe(6);
    check("a acked", port_out & 8'hba, 8'ha8);
    check("a stat acked", {5'h00, stat_a}, 8'h01);
    strobe(2);
    check("b acked", port_out & 8'hba, 8'haa);
    check("b stat acked", {5'h00, stat_b}, 8'h01);
    check("b ack no latch", 8'(n_lb), 8'h01);
  endtask : t_stb_out

  task automatic t_bidir;
    set_cfg('{pcm_pkg::PCM_A_BIDIR, pcm_pkg::PCM_B_STB_IN, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1});
    check("bidir oe", port_oe, 8'haf);
    check("bidir idle", port_out & 8'ha7, 8'h85);
    check("bidir gp_in", gp_in, 8'h05);
    strobe(4);
    check("bidir full", port_out & 8'ha7, 8'ha5);
    check("bidir latch", 8'(n_la), 8'h02);
    check("bidir b quiet", {5'h00, stat_b}, 8'h00);
  endtask : t_bidir

  // Reset in mid-run must drop every driver at once
  task automatic t_mid_reset;
    @(posedge clk);
    nrst <= 1'b0;
    tick(1);
    check("mid reset oe", port_oe, 8'h00);
    @(posedge clk);
    nrst <= 1'b1;
    tick(2);
    check("after reset oe", port_oe, 8'h00);
    check("after reset gp_in", gp_in, 8'h7c);
  endtask : t_mid_reset

  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  always @(negedge clk)
    if (a_latch === 1'b1)
      n_la++;

  always @(negedge clk)
    if (b_latch === 1'b1)
      n_lb++;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Whole run needs some 75 cycles; 2000 leaves ample margin
  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    nrst = 1'b0;
    cfg = '0;
    cfg_valid = 1'b0;
    evt_a = '0;
    evt_b = '0;
    gp_out = 8'ha5;
    // Idle handshake lines 6, 4 and 2 rest high like the pull-ups
    gp_drv = 8'h7c;
    pulse_req = '0;
    tick(3);
    check("reset oe", port_oe, 8'h00);
    check("reset gp_in", gp_in, 8'h00);
    @(posedge clk);
    @(posedge clk);
    nrst <= 1'b1;
    t_simple();
    t_stb_in();
    t_stb_out();
    t_bidir();
    t_mid_reset();
    wrap_up();
  end
endmodule : tb_ppi_port_c_signal_mux
